// [gyro_pkg.sv]
// Shared constants and types for the rate-sensor alarm, identification and bias command block.
package gyro_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [6:0] ADDR_RATE = 7'h04;
    localparam logic [6:0] ADDR_TRIM = 7'h14;
    localparam logic [6:0] ADDR_MAG1 = 7'h20;
    localparam logic [6:0] ADDR_MAG2 = 7'h22;
    localparam logic [6:0] ADDR_SMPL1 = 7'h24;
    localparam logic [6:0] ADDR_SMPL2 = 7'h26;
    localparam logic [6:0] ADDR_CTRL = 7'h28;
    localparam logic [6:0] ADDR_PRD = 7'h36;
    localparam logic [6:0] ADDR_AVG = 7'h38;
    localparam logic [6:0] ADDR_ALSTAT = 7'h3c;
    localparam logic [6:0] ADDR_CMD = 7'h3e;
    localparam logic [6:0] ADDR_LOT_LO = 7'h52;
    localparam logic [6:0] ADDR_LOT_HI = 7'h54;
    localparam logic [6:0] ADDR_PROD = 7'h56;
    localparam logic [6:0] ADDR_SERIAL = 7'h58;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_LINE_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_EN_BIT = 2;
    localparam int CTRL_FILT_BIT = 4;
    localparam int CTRL_SRC_LSB = 8;
    localparam int CTRL_DYN_BIT = 11;
    localparam int CTRL_ALARM_STRIDE = 4;
    localparam int MAG_POL_BIT = 15;
    localparam int CMD_AUTO_BIT = 0;
    localparam int CMD_STORE_BIT = 3;
    localparam logic [2:0] SRC_RATE = 3'h2;
    localparam int NUM_ALARMS = 2;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int CLK_HZ = 100_000_000;
    localparam int MAX_RATE_SPS = 2429;
    localparam int SAMPLE_BASE_CYCLES = CLK_HZ / MAX_RATE_SPS;
    localparam int LINK_WORD_BITS = 16;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } cmd_word_type;

    typedef struct packed {
        logic active;
        logic dynamic;
        logic [15:0] mag;
        logic [7:0] count;
    } alarm_cfg_type;

endpackage

// [gyro_alarm_unit.sv]
// One alarm channel: static level or dynamic rate-of-change comparison.
`timescale 1ns/1ns
module gyro_alarm_unit (
    input wire logic clk, // System clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic tick, // One new sample this cycle.
    input wire logic [15:0] sample, // Selected rate data, two's complement.
    input wire gyro_pkg::alarm_cfg_type cfg, // Channel configuration.
    output logic flag // Alarm condition, held between evaluations.
);

    logic [7:0] cnt_q, cnt_d;
    logic [15:0] ref_q, ref_d;
    logic primed_q, primed_d;
    logic flag_q, flag_d;
    logic [7:0] need;
    logic signed [16:0] diff;
    logic [15:0] mag_abs;
    logic signed [15:0] level;
    logic greater;

    // ****************************************
    // Comparison
    // ****************************************

    // Works out the next state on each new sample.
    always_comb begin
        cnt_d = cnt_q;
        ref_d = ref_q;
        primed_d = primed_q;
        flag_d = flag_q;
        need = (cfg.count <= 8'h01) ? 8'h01 : cfg.count;
        diff = $signed({sample[15], sample}) - $signed({ref_q[15], ref_q});
        mag_abs = {2'h0, cfg.mag[13:0]};
        level = $signed({{2{cfg.mag[13]}}, cfg.mag[13:0]});
        greater = cfg.mag[gyro_pkg::MAG_POL_BIT];
        if (!cfg.active) begin
            cnt_d = 8'h00;
            primed_d = 1'b0;
            flag_d = 1'b0;
        end else if (tick) begin
            if (cfg.dynamic) begin
                if (!primed_q) begin
                    ref_d = sample;
                    primed_d = 1'b1;
                    cnt_d = 8'h00;
                end else if (cnt_q + 8'h01 >= need) begin
                    // Period spans need sample intervals of the current sample period.
                    if (diff < 0) begin
                        diff = -diff;
                    end
                    if (greater) begin
                        flag_d = diff > $signed({1'b0, mag_abs});
                    end else begin
                        flag_d = diff < $signed({1'b0, mag_abs});
                    end
                    ref_d = sample;
                    cnt_d = 8'h00;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end else begin
                primed_d = 1'b0;
                flag_d = greater ? ($signed(sample) > level) : ($signed(sample) < level);
            end
        end
    end

    // Registers the channel state.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 8'h00;
            ref_q <= gyro_pkg::REG_RESET;
            primed_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ref_q <= ref_d;
            primed_q <= primed_d;
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;

endmodule

// [gyro_control_top.sv]
// Serial register port, alarms, identification registers and bias commands of the rate sensor.
`timescale 1ns/1ns
module gyro_control_top #(
    parameter int SAMPLE_BASE = gyro_pkg::SAMPLE_BASE_CYCLES, // Cycles per sample at maximum rate.
    parameter logic [15:0] LOT_LOW_VALUE = 16'h1111, // Arbitrary value.
    parameter logic [15:0] LOT_HIGH_VALUE = 16'h2222, // Arbitrary value.
    parameter logic [15:0] PRODUCT_VALUE = 16'h5a5a, // Arbitrary value.
    parameter logic [15:0] SERIAL_VALUE = 16'h0042 // Arbitrary value.
) (
    input wire logic SYS_CLK, // System clock, 100 MHz.
    input wire logic ARST_N, // Asynchronous reset, active low.
    input wire logic SPI_SCLK, // Link clock from the host, idles high.
    input wire logic SPI_CS_N, // Frame select, active low.
    input wire logic SPI_MOSI, // Command data from the host.
    output logic SPI_MISO, // Read data to the host.
    output logic SPI_MISO_OE, // High while the data line is driven.
    input wire logic [15:0] RATE_RAW, // Unfiltered rate output.
    input wire logic [15:0] RATE_FILT, // Filtered rate output.
    output logic SAMPLE_TICK, // One pulse per sample period.
    output logic [15:0] RATE_OFFSET_TRIM, // Offset trim to the signal chain.
    output logic [15:0] AVERAGING_SETTING, // Averaging setting to the filter.
    output logic TRIM_STORE_PULSE, // Request to store trim in nonvolatile memory.
    output logic FIRST_DIGITAL_LINE_O, // First digital line level.
    output logic FIRST_DIGITAL_LINE_OE, // First digital line driven.
    output logic SECOND_DIGITAL_LINE_O, // Second digital line level.
    output logic SECOND_DIGITAL_LINE_OE // Second digital line driven.
);

    // ****************************************
    // Link domain
    // ****************************************

    logic [3:0] bit_q;
    logic [14:0] shift_q;
    logic [15:0] word_q;
    logic toggle_q;
    logic [15:0] tx_q;
    logic first_q;
    logic [15:0] rd_q, rd_d;

    // Shifts in command bits on rising edges; the frame select clears the count.
    always_ff @(posedge SPI_SCLK or posedge SPI_CS_N) begin
        if (SPI_CS_N) begin
            bit_q <= 4'h0;
            shift_q <= 15'h0000;
        end else begin
            bit_q <= bit_q + 4'h1;
            shift_q <= {shift_q[13:0], SPI_MOSI};
        end
    end

    // Captures each whole word and flips the event toggle; the word stays put for a full word time.
    always_ff @(posedge SPI_SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            word_q <= 16'h0000;
            toggle_q <= 1'b0;
        end else if (!SPI_CS_N && bit_q == 4'hf) begin
            word_q <= {shift_q, SPI_MOSI};
            toggle_q <= ~toggle_q;
        end
    end

    // Shifts out read data on falling edges; the first bit comes straight from the read register.
    always_ff @(negedge SPI_SCLK or posedge SPI_CS_N) begin
        if (SPI_CS_N) begin
            tx_q <= 16'h0000;
            first_q <= 1'b0;
        end else if (!first_q) begin
            tx_q <= {rd_q[14:0], 1'b0};
            first_q <= 1'b1;
        end else begin
            tx_q <= {tx_q[14:0], 1'b0};
        end
    end

    // The read register is quiet during a frame, so reading it here is safe.
    assign SPI_MISO = first_q ? tx_q[15] : rd_q[15];
    assign SPI_MISO_OE = ~SPI_CS_N;

    // ****************************************
    // Word event crossing
    // ****************************************

    logic [2:0] sync_q;

    // Three-stage synchroniser on the toggle; the last two stages detect the change.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], toggle_q};
        end
    end

    logic word_evt;
    gyro_pkg::cmd_word_type cmd;
    assign word_evt = sync_q[1] ^ sync_q[2];
    assign cmd = word_q;

    // ****************************************
    // Sample timing
    // ****************************************

    logic [31:0] base_q, base_d;
    logic [7:0] prd_q, prd_d;
    logic tick_q, tick_d;
    logic [15:0] sample_period_setting_q;

    // Base interval at maximum rate, stretched by the sample-period setting.
    always_comb begin
        base_d = base_q + 32'h1;
        prd_d = prd_q;
        tick_d = 1'b0;
        if (base_q >= 32'(SAMPLE_BASE - 1)) begin
            base_d = 32'h0;
            if (prd_q >= sample_period_setting_q[7:0]) begin
                prd_d = 8'h00;
                tick_d = 1'b1;
            end else begin
                prd_d = prd_q + 8'h01;
            end
        end
    end

    // Registers the sample timing.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            base_q <= 32'h0;
            prd_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            base_q <= base_d;
            prd_q <= prd_d;
            tick_q <= tick_d;
        end
    end

    assign SAMPLE_TICK = tick_q;

    // ****************************************
    // Register file
    // ****************************************

    logic [15:0] mag_q [gyro_pkg::NUM_ALARMS];
    logic [15:0] mag_d [gyro_pkg::NUM_ALARMS];
    logic [15:0] cnt_q [gyro_pkg::NUM_ALARMS];
    logic [15:0] cnt_d [gyro_pkg::NUM_ALARMS];
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] sample_period_setting_d;
    logic [15:0] avg_q, avg_d;
    logic [15:0] trim_q, trim_d;
    logic [15:0] rate_q, rate_d;
    logic auto_q, auto_d;
    logic store_q, store_d;
    logic [1:0] flags;

    // Replaces one byte of a 16-bit register; an even address holds the low byte.
    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi, input logic [7:0] val);
        logic [15:0] res;
        res = old;
        if (hi) begin
            res[15:8] = val;
        end else begin
            res[7:0] = val;
        end
        return res;
    endfunction

    // Decodes command words, handles the global commands and prepares read data.
    always_comb begin
        logic [6:0] even;
        even = {cmd.addr[6:1], 1'b0};
        mag_d = mag_q;
        cnt_d = cnt_q;
        ctrl_d = ctrl_q;
        sample_period_setting_d = sample_period_setting_q;
        avg_d = avg_q;
        trim_d = trim_q;
        rd_d = rd_q;
        auto_d = auto_q;
        store_d = 1'b0;
        rate_d = tick_q ? RATE_RAW : rate_q;
        if (auto_q && tick_q) begin
            trim_d = 16'(-RATE_RAW);
            auto_d = 1'b0;
        end
        if (word_evt && cmd.wr) begin
            case (even)
                gyro_pkg::ADDR_MAG1: mag_d[0] = put_byte(mag_q[0], cmd.addr[0], cmd.data);
                gyro_pkg::ADDR_MAG2: mag_d[1] = put_byte(mag_q[1], cmd.addr[0], cmd.data);
                gyro_pkg::ADDR_SMPL1: cnt_d[0] = put_byte(cnt_q[0], cmd.addr[0], cmd.data);
                gyro_pkg::ADDR_SMPL2: cnt_d[1] = put_byte(cnt_q[1], cmd.addr[0], cmd.data);
                gyro_pkg::ADDR_CTRL: ctrl_d = put_byte(ctrl_q, cmd.addr[0], cmd.data);
                gyro_pkg::ADDR_PRD: sample_period_setting_d = put_byte(sample_period_setting_q, cmd.addr[0], cmd.data);
                gyro_pkg::ADDR_AVG: avg_d = put_byte(avg_q, cmd.addr[0], cmd.data);
                gyro_pkg::ADDR_TRIM: trim_d = put_byte(trim_q, cmd.addr[0], cmd.data);
                gyro_pkg::ADDR_CMD: begin
                    if (!cmd.addr[0]) begin
                        auto_d = auto_q | cmd.data[gyro_pkg::CMD_AUTO_BIT];
                        store_d = cmd.data[gyro_pkg::CMD_STORE_BIT];
                    end
                end
                default: begin
                end
            endcase
        end else if (word_evt) begin
            case (even)
                gyro_pkg::ADDR_RATE: rd_d = rate_q;
                gyro_pkg::ADDR_TRIM: rd_d = trim_q;
                gyro_pkg::ADDR_MAG1: rd_d = mag_q[0];
                gyro_pkg::ADDR_MAG2: rd_d = mag_q[1];
                gyro_pkg::ADDR_SMPL1: rd_d = cnt_q[0];
                gyro_pkg::ADDR_SMPL2: rd_d = cnt_q[1];
                gyro_pkg::ADDR_CTRL: rd_d = ctrl_q;
                gyro_pkg::ADDR_PRD: rd_d = sample_period_setting_q;
                gyro_pkg::ADDR_AVG: rd_d = avg_q;
                gyro_pkg::ADDR_ALSTAT: rd_d = {14'h0000, flags};
                gyro_pkg::ADDR_LOT_LO: rd_d = LOT_LOW_VALUE;
                gyro_pkg::ADDR_LOT_HI: rd_d = LOT_HIGH_VALUE;
                gyro_pkg::ADDR_PROD: rd_d = PRODUCT_VALUE;
                gyro_pkg::ADDR_SERIAL: rd_d = SERIAL_VALUE;
                default: rd_d = 16'h0000;
            endcase
        end
    end

    // Registers the register file.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < gyro_pkg::NUM_ALARMS; i++) begin
                mag_q[i] <= gyro_pkg::REG_RESET;
                cnt_q[i] <= gyro_pkg::REG_RESET;
            end
            ctrl_q <= gyro_pkg::REG_RESET;
            sample_period_setting_q <= gyro_pkg::REG_RESET;
            avg_q <= gyro_pkg::REG_RESET;
            trim_q <= gyro_pkg::REG_RESET;
            rate_q <= gyro_pkg::REG_RESET;
            rd_q <= gyro_pkg::REG_RESET;
            auto_q <= 1'b0;
            store_q <= 1'b0;
        end else begin
            mag_q <= mag_d;
            cnt_q <= cnt_d;
            ctrl_q <= ctrl_d;
            sample_period_setting_q <= sample_period_setting_d;
            avg_q <= avg_d;
            trim_q <= trim_d;
            rate_q <= rate_d;
            rd_q <= rd_d;
            auto_q <= auto_d;
            store_q <= store_d;
        end
    end

    assign RATE_OFFSET_TRIM = trim_q;
    assign AVERAGING_SETTING = avg_q;
    assign TRIM_STORE_PULSE = store_q;

    // ****************************************
    // Alarm channels
    // ****************************************

    logic [15:0] alarm_src;
    assign alarm_src = ctrl_q[gyro_pkg::CTRL_FILT_BIT] ? RATE_FILT : RATE_RAW;

    generate
        for (genvar g = 0; g < gyro_pkg::NUM_ALARMS; g++) begin : gen_alarm
            gyro_pkg::alarm_cfg_type cfg;
            // Only the rate output is wired as a source; other selections disable the channel.
            assign cfg.active = ctrl_q[gyro_pkg::CTRL_SRC_LSB + g * gyro_pkg::CTRL_ALARM_STRIDE +: 3]
                == gyro_pkg::SRC_RATE;
            assign cfg.dynamic = ctrl_q[gyro_pkg::CTRL_DYN_BIT + g * gyro_pkg::CTRL_ALARM_STRIDE];
            assign cfg.mag = mag_q[g];
            assign cfg.count = cnt_q[g][7:0];
            gyro_alarm_unit u_alarm (
                .clk(SYS_CLK),
                .arst_n(ARST_N),
                .tick(tick_q),
                .sample(alarm_src),
                .cfg(cfg),
                .flag(flags[g])
            );
        end
    endgenerate

    // ****************************************
    // Indicator output
    // ****************************************

    logic line_q, line_d;
    logic level;

    // Applies polarity, then registers the indicator level.
    always_comb begin
        level = |flags;
        line_d = ctrl_q[gyro_pkg::CTRL_POL_BIT] ? level : ~level;
    end

    // Registers the indicator level.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            line_q <= 1'b1;
        end else begin
            line_q <= line_d;
        end
    end

    // Routes the indicator to one line when enabled.
    assign FIRST_DIGITAL_LINE_O = line_q;
    assign SECOND_DIGITAL_LINE_O = line_q;
    assign FIRST_DIGITAL_LINE_OE = ctrl_q[gyro_pkg::CTRL_EN_BIT] & ~ctrl_q[gyro_pkg::CTRL_LINE_BIT];
    assign SECOND_DIGITAL_LINE_OE = ctrl_q[gyro_pkg::CTRL_EN_BIT] & ctrl_q[gyro_pkg::CTRL_LINE_BIT];

endmodule

// [gyro_host_model.sv]
// Host processor model that drives the serial command link of the rate sensor.
`timescale 1ns/1ns
module gyro_host_model #(
    parameter int STORE_WAIT_NS = 500 // Shortened settle time after a trim store.
) (
    output logic sclk, // Link clock, idles high.
    output logic cs_n, // Frame select, active low.
    output logic mosi, // Command data to the device.
    input wire logic miso // Read data from the device.
);
    // ********
    // Link transfers
    // ********
    // The link idles with the clock high; between frames the clock stands still and the data line flips once.
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b1;
    end
    // Sends one word MSB first on falling edges; each read bit is taken just before the falling edge.
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        cs_n = 1'b0;
        #5;
        for (int i = 15; i >= 0; i--) begin
            r[i] = miso;
            sclk = 1'b0;
            mosi = w[i];
            #3;
            sclk = 1'b1;
            #3;
        end
        cs_n = 1'b0;
        #3;
        cs_n = 1'b1;
        mosi = ~mosi;
        #60;
        if (w[15] && w[14:8] == gyro_pkg::ADDR_CMD && w[3]) begin
            #(STORE_WAIT_NS);
        end
    endtask
    // A 16-bit register is written low byte first, then high byte.
    task automatic wr16(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] r;
        xfer({1'b1, a, v[7:0]}, r);
        xfer({1'b1, a | 7'h01, v[15:8]}, r);
    endtask
    // A read word is answered during the following frame.
    task automatic rd16(input logic [6:0] a, output logic [15:0] v);
        xfer({1'b0, a, 8'h00}, v);
        xfer({1'b0, a, 8'h00}, v);
    endtask
endmodule

// [gyro_control_chk.sv]
// Concurrent checks on the ports of the rate-sensor control block.
`timescale 1ns/1ns
module gyro_control_chk #(
    parameter int SAMPLE_BASE = 10 // Cycles per sample at maximum rate.
) (
    input wire logic SYS_CLK, // System clock.
    input wire logic ARST_N, // Reset, active low.
    input wire logic SPI_CS_N, // Frame select.
    input wire logic SPI_MISO_OE, // Data line driven.
    input wire logic SAMPLE_TICK, // Sample pulse.
    input wire logic [15:0] RATE_OFFSET_TRIM, // Trim value.
    input wire logic [15:0] AVERAGING_SETTING, // Averaging value.
    input wire logic TRIM_STORE_PULSE, // Store request.
    input wire logic FIRST_DIGITAL_LINE_O, // First line level.
    input wire logic FIRST_DIGITAL_LINE_OE, // First line driven.
    input wire logic SECOND_DIGITAL_LINE_O, // Second line level.
    input wire logic SECOND_DIGITAL_LINE_OE // Second line driven.
);
    // ********
    // Helper counters and assertions
    // ********
    logic [3:0] age_q, age_d;
    int gap_q, gap_d;
    // Counts cycles since the frame select was low and since the last sample pulse.
    always_comb begin
        age_d = SPI_CS_N ? age_q + {3'h0, age_q != 4'hf} : 4'h0;
        gap_d = SAMPLE_TICK ? 1 : (gap_q < SAMPLE_BASE ? gap_q + 1 : gap_q);
    end
    // Registers the helper counters.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            age_q <= 4'h0;
            gap_q <= SAMPLE_BASE;
        end else begin
            age_q <= age_d;
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    a_tick_spacing: assert property (SAMPLE_TICK |-> gap_q >= SAMPLE_BASE)
        else $error("sample pulses closer than the base period");
    a_miso_enable: assert property (SPI_MISO_OE == !SPI_CS_N)
        else $error("data line enable differs from frame select");
    a_lines_exclusive: assert property (!(FIRST_DIGITAL_LINE_OE && SECOND_DIGITAL_LINE_OE))
        else $error("both indicator lines driven");
    a_store_one_cycle: assert property ($rose(TRIM_STORE_PULSE) |=> !TRIM_STORE_PULSE)
        else $error("store pulse longer than one cycle");
    a_store_after_word: assert property ($rose(TRIM_STORE_PULSE) |-> age_q < 4'ha)
        else $error("store pulse without a command word");
    a_trim_cause: assert property ($changed(RATE_OFFSET_TRIM) |-> age_q < 4'ha || $past(SAMPLE_TICK) ||
        $past(SAMPLE_TICK, 2))
        else $error("trim changed without a write or a sample");
    a_avg_cause: assert property ($changed(AVERAGING_SETTING) |-> age_q < 4'ha)
        else $error("averaging changed without a write");
    a_first_cause: assert property ($changed(FIRST_DIGITAL_LINE_O) |-> age_q < 4'ha || $past(SAMPLE_TICK, 2))
        else $error("first line changed outside an evaluation");
    a_second_cause: assert property ($changed(SECOND_DIGITAL_LINE_O) |-> age_q < 4'ha || $past(SAMPLE_TICK, 2))
        else $error("second line changed outside an evaluation");
    c_store: cover property (TRIM_STORE_PULSE);
    c_first_active: cover property (FIRST_DIGITAL_LINE_OE && !FIRST_DIGITAL_LINE_O);
    c_second_on: cover property (SECOND_DIGITAL_LINE_OE);
endmodule
bind gyro_control_top gyro_control_chk #(.SAMPLE_BASE(SAMPLE_BASE)) chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .SPI_CS_N(SPI_CS_N), .SPI_MISO_OE(SPI_MISO_OE), .SAMPLE_TICK(SAMPLE_TICK), .RATE_OFFSET_TRIM(RATE_OFFSET_TRIM),
    .AVERAGING_SETTING(AVERAGING_SETTING), .TRIM_STORE_PULSE(TRIM_STORE_PULSE),
    .FIRST_DIGITAL_LINE_O(FIRST_DIGITAL_LINE_O), .FIRST_DIGITAL_LINE_OE(FIRST_DIGITAL_LINE_OE),
    .SECOND_DIGITAL_LINE_O(SECOND_DIGITAL_LINE_O), .SECOND_DIGITAL_LINE_OE(SECOND_DIGITAL_LINE_OE));

// [gyro_alarm_id_bias_control_tb.sv]
// Self-checking testbench for the rate-sensor control block.
`timescale 1ns/1ns
module gyro_alarm_id_bias_control_tb;
    // ********
    // Signals, clock and instances
    // ********
    localparam int BASE = 10;
    logic sys_clk, arst_n, sclk, cs_n, mosi, miso, miso_oe, miso_w, miso_last, tick, store, store_seen;
    logic l1, l1_oe, l2, l2_oe;
    logic [15:0] trim, avg, base, acc, step, rate;
    int num_errors = 0;
    int compares = 0;
    // An undriven data line shows the inverse of its last driven level.
    assign miso_w = miso_oe ? miso : ~miso_last;
    assign rate = base + acc;
    always @(posedge sys_clk) if (miso_oe === 1'b1) miso_last <= miso;
    // The rate input ramps by the step at every sample; store pulses are latched.
    always @(negedge sys_clk) if (tick === 1'b1) acc <= acc + step;
    always @(posedge sys_clk) if (store === 1'b1) store_seen <= 1'b1;
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    gyro_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));
    gyro_control_top #(.SAMPLE_BASE(BASE), .LOT_LOW_VALUE(16'h1357), .LOT_HIGH_VALUE(16'h2468),
        .PRODUCT_VALUE(16'h0c0d), .SERIAL_VALUE(16'h00a5)) dut (.SYS_CLK(sys_clk), .ARST_N(arst_n),
        .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe),
        .RATE_RAW(rate), .RATE_FILT(~rate), .SAMPLE_TICK(tick), .RATE_OFFSET_TRIM(trim),
        .AVERAGING_SETTING(avg), .TRIM_STORE_PULSE(store), .FIRST_DIGITAL_LINE_O(l1),
        .FIRST_DIGITAL_LINE_OE(l1_oe), .SECOND_DIGITAL_LINE_O(l2), .SECOND_DIGITAL_LINE_OE(l2_oe));
    // ********
    // Shared tasks
    // ********
    task automatic give_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    // Counts cycles up to the next sample pulse, giving up after a bound.
    task automatic next_tick(output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (tick !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic wait_ticks(input int k);
        int n;
        repeat (k) next_tick(n);
    endtask
    // ********
    // Scenarios
    // ********
    // Identification reads, a refused write to a read-only place, an unmapped read and the rate readback.
    task automatic t_ident();
        logic [6:0] a [6] = '{gyro_pkg::ADDR_LOT_LO, gyro_pkg::ADDR_LOT_HI, gyro_pkg::ADDR_PROD,
            gyro_pkg::ADDR_SERIAL, 7'h5a, gyro_pkg::ADDR_RATE};
        logic [15:0] e [6] = '{16'h1357, 16'h2468, 16'h0c0d, 16'h00a5, 16'h0000, 16'h0123};
        logic [15:0] v;
        host.wr16(gyro_pkg::ADDR_LOT_LO, 16'hffff);
        for (int i = 0; i < 6; i++) begin
            host.rd16(a[i], v);
            check("identification word", e[i], v);
        end
    endtask
    // Sample pulse spacing for period settings of one and zero.
    task automatic t_period();
        int n;
        for (int s = 1; s >= 0; s--) begin
            host.wr16(gyro_pkg::ADDR_PRD, 16'(s));
            wait_ticks(2);
            next_tick(n);
            check("sample period", 16'(BASE * (s + 1)), 16'(n));
        end
    endtask
    // Averaging write, manual trim, store command and single-sample correction.
    task automatic t_bias();
        logic [15:0] r;
        host.wr16(gyro_pkg::ADDR_AVG, 16'h0100);
        check("averaging setting", 16'h0100, avg);
        host.wr16(gyro_pkg::ADDR_TRIM, 16'h0000 - rate);
        check("manual trim", 16'hfedd, trim);
        store_seen = 1'b0;
        host.xfer({1'b1, gyro_pkg::ADDR_CMD, 8'h08}, r);
        check("store pulse", 16'h0001, {15'h0000, store_seen});
        base = 16'h0040;
        host.xfer({1'b1, gyro_pkg::ADDR_CMD, 8'h01}, r);
        wait_ticks(2);
        check("automatic trim", 16'hffc0, trim);
    endtask
    // Dynamic alarms on a steady and a ramping rate, count of zero, line and polarity choice.
    task automatic t_alarm();
        logic [15:0] v;
        host.wr16(gyro_pkg::ADDR_SMPL1, 16'h0002);
        host.wr16(gyro_pkg::ADDR_SMPL2, 16'h0002);
        host.wr16(gyro_pkg::ADDR_MAG1, 16'h8100);
        host.wr16(gyro_pkg::ADDR_MAG2, 16'h000a);
        host.wr16(gyro_pkg::ADDR_CTRL, 16'haa04);
        wait_ticks(8);
        host.rd16(gyro_pkg::ADDR_ALSTAT, v);
        check("steady alarm flags", 16'h0002, v);
        check("first line active low", 16'h0002, {13'h0000, l2_oe, l1_oe, l1});
        step = 16'h0100;
        wait_ticks(8);
        host.rd16(gyro_pkg::ADDR_ALSTAT, v);
        check("ramp alarm flags", 16'h0001, v);
        host.wr16(gyro_pkg::ADDR_SMPL1, 16'h0000);
        wait_ticks(8);
        host.rd16(gyro_pkg::ADDR_ALSTAT, v);
        check("single sample flags", 16'h0000, v);
        check("first line idle", 16'h0003, {13'h0000, l2_oe, l1_oe, l1});
        host.wr16(gyro_pkg::ADDR_CTRL, 16'haa05);
        wait_ticks(4);
        check("second line idle", 16'h0005, {13'h0000, l2_oe, l1_oe, l2});
        host.wr16(gyro_pkg::ADDR_CTRL, 16'haa06);
        wait_ticks(4);
        check("first line active high", 16'h0002, {13'h0000, l2_oe, l1_oe, l1});
        step = 16'h0000;
    endtask
    // Main sequence.
    initial begin
        arst_n = 1'b0;
        base = 16'h0123;
        acc = 16'h0000;
        step = 16'h0000;
        miso_last = 1'b0;
        store_seen = 1'b0;
        repeat (12) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_ident();
        t_period();
        t_bias();
        t_alarm();
        give_verdict();
    end
endmodule
